// [design/chiller_regs_pkg.sv]
package chiller_regs_pkg;

   // Word indices of the sixteen-word bank
   localparam logic [15:0] ADDR_DISCH_TEMP   = 16'h0000;
   localparam logic [15:0] ADDR_DISCH_PRESS  = 16'h0002;
   localparam logic [15:0] ADDR_FLUID_COND   = 16'h0003;
   localparam logic [15:0] ADDR_STATUS_PRI   = 16'h0004;
   localparam logic [15:0] ADDR_ALARM_A      = 16'h0005;
   localparam logic [15:0] ADDR_ALARM_B      = 16'h0006;
   localparam logic [15:0] ADDR_ALARM_C      = 16'h0007;
   localparam logic [15:0] ADDR_STATUS_SEC   = 16'h0009;
   localparam logic [15:0] ADDR_SETPOINT     = 16'h000b;
   localparam logic [15:0] ADDR_RUN_CMD      = 16'h000c;
   localparam logic [15:0] ADDR_LAST         = 16'h000f;
   localparam int          WORD_COUNT        = 16;

   // Setpoint limits, 0.1 degree per count
   localparam logic [15:0] SETP_MIN_C        = 16'h0032;
   localparam logic [15:0] SETP_MAX_C        = 16'h0190;
   localparam logic [15:0] SETP_MIN_F        = 16'h019a;
   localparam logic [15:0] SETP_MAX_F        = 16'h0410;

   // Value ranges of the plant inputs
   localparam logic [15:0] TEMP_MIN_C        = 16'hfbb4;
   localparam logic [15:0] TEMP_MAX_C        = 16'h05dc;
   localparam logic [15:0] TEMP_MIN_F        = 16'hf984;
   localparam logic [15:0] TEMP_MAX_F        = 16'h0bcc;
   localparam logic [15:0] PRESS_MAX_MPA     = 16'h012c;
   localparam logic [15:0] PRESS_MAX_PSI     = 16'h01b3;
   localparam logic [15:0] RESIST_MAX        = 16'h002d;
   localparam logic [15:0] COND_MIN          = 16'h0014;
   localparam logic [15:0] COND_MAX          = 16'h01e0;

   // Reset values
   localparam logic [15:0] SETP_RESET        = 16'h0190;
   localparam logic        RUN_CMD_RESET     = 1'b0;

   // Primary status word bit positions
   localparam int BIT_RUN        = 0;
   localparam int BIT_STOP_ALARM = 1;
   localparam int BIT_CONT_ALARM = 2;
   localparam int BIT_PRESS_UNIT = 4;
   localparam int BIT_REMOTE     = 5;
   localparam int BIT_TEMP_READY = 9;
   localparam int BIT_TEMP_UNIT  = 10;
   localparam int BIT_RUN_TIMER  = 11;
   localparam int BIT_STOP_TIMER = 12;
   localparam int BIT_RESTART_PF = 13;
   localparam int BIT_ANTI_FREEZE= 14;
   localparam int BIT_AUTO_FILL  = 15;

   // Error code for an out-of-range address
   localparam logic [7:0] ERR_BAD_ADDR = 8'h02;

   // Sensor selection in the secondary status word
   typedef enum logic [1:0] {
      SENSOR_NONE   = 2'h0,
      SENSOR_RESIST = 2'h1,
      SENSOR_COND   = 2'h2
   } sensor_sel_e;

   // Plant inputs that travel together
   typedef struct packed {
      logic [15:0] panelPresentValue;
      logic [15:0] dischPressure;
      logic [15:0] fluidCond;
      logic [15:0] alarmA;
      logic [15:0] alarmB;
      logic [15:0] alarmC;
      logic        running;
      logic        stopAlarm;
      logic        contAlarm;
      logic        pressUnitPsi;
      logic        remoteSerial;
      logic        tempReady;
      logic        tempUnitF;
      logic        runTimerSet;
      logic        stopTimerSet;
      logic        restartPfSet;
      logic        antiFreezeSet;
      logic        autoFillActive;
      logic        sensorEnabled;
      logic [1:0]  sensorSel;
   } plant_s;

   // Request from the protocol engine
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic [4:0]  count;
      logic [15:0] data;
   } reg_req_s;

endpackage : chiller_regs_pkg

// [design/chiller_process_register_map.sv]
`timescale 1ns/1ps
module chiller_process_register_map
   import chiller_regs_pkg::*;
(
   input  wire logic         sys_clk,
   input  wire logic         sys_rst,
   input  wire plant_s       plant,
   input  wire reg_req_s     req,
   output logic              reqReady,
   output logic              rspValid,
   output logic              rspError,
   output logic [7:0]        rspErrCode,
   output logic [WORD_COUNT*16-1:0] rspWords,
   output logic [15:0]       setpoint,
   output logic              runCommand
);

   logic [15:0]              setpointReg;
   logic [15:0]              setpointNext;
   logic                     runCmdReg;
   logic                     runCmdNext;
   logic                     rspValidReg;
   logic                     rspValidNext;
   logic                     rspErrorReg;
   logic                     rspErrorNext;
   logic [7:0]               errCodeReg;
   logic [7:0]               errCodeNext;
   logic [WORD_COUNT*16-1:0] snapReg;
   logic [WORD_COUNT*16-1:0] snapNext;
   logic [15:0]              statusPri;
   logic [15:0]              statusSec;
   logic [15:0]              condWord;
   logic [15:0]              setpMin;
   logic [15:0]              setpMax;
   logic [15:0]              setpClamped;
   logic [WORD_COUNT*16-1:0] liveWords;
   logic [16:0]              lastAddr;
   logic                     addrBad;

   // The bank answers every request in the cycle after it is taken
   assign reqReady = 1'b1;

   // Primary status word; unused bits stay zero
   always_comb begin
      statusPri = 16'h0000;
      statusPri[BIT_RUN]         = plant.running;
      statusPri[BIT_STOP_ALARM]  = plant.stopAlarm;
      statusPri[BIT_CONT_ALARM]  = plant.contAlarm;
      statusPri[BIT_PRESS_UNIT]  = plant.pressUnitPsi;
      statusPri[BIT_REMOTE]      = plant.remoteSerial;
      statusPri[BIT_TEMP_READY]  = plant.tempReady;
      statusPri[BIT_TEMP_UNIT]   = plant.tempUnitF;
      statusPri[BIT_RUN_TIMER]   = plant.runTimerSet;
      statusPri[BIT_STOP_TIMER]  = plant.stopTimerSet;
      statusPri[BIT_RESTART_PF]  = plant.restartPfSet;
      statusPri[BIT_ANTI_FREEZE] = plant.antiFreezeSet;
      // fill state, follows plant even without the option
      statusPri[BIT_AUTO_FILL]   = plant.autoFillActive;
   end

   // Secondary status and sensor word
   always_comb begin
      statusSec = {14'h0000, plant.sensorSel};
      condWord  = plant.sensorEnabled ? plant.fluidCond : 16'h0000;
   end

   // Live image of the whole bank, reserved words tied to zero
   always_comb begin
      liveWords = '0;
      liveWords[ADDR_DISCH_TEMP*16 +: 16]  = plant.panelPresentValue;
      liveWords[ADDR_DISCH_PRESS*16 +: 16] = plant.dischPressure;
      liveWords[ADDR_FLUID_COND*16 +: 16]  = condWord;
      liveWords[ADDR_STATUS_PRI*16 +: 16]  = statusPri;
      liveWords[ADDR_ALARM_A*16 +: 16]     = plant.alarmA;
      liveWords[ADDR_ALARM_B*16 +: 16]     = plant.alarmB;
      liveWords[ADDR_ALARM_C*16 +: 16]     = plant.alarmC;
      liveWords[ADDR_STATUS_SEC*16 +: 16]  = statusSec;
      liveWords[ADDR_SETPOINT*16 +: 16]    = setpointReg;
      liveWords[ADDR_RUN_CMD*16 +: 16]     = {15'h0000, runCmdReg};
   end

   // Limits follow the selected temperature unit
   always_comb begin
      setpMin = plant.tempUnitF ? SETP_MIN_F : SETP_MIN_C;
      setpMax = plant.tempUnitF ? SETP_MAX_F : SETP_MAX_C;
      if (req.data > setpMax) begin
         setpClamped = setpMax;
      end else if (req.data < setpMin) begin
         setpClamped = setpMin;
      end else begin
         setpClamped = req.data;
      end
   end

   // Range check covers the last word of a burst as well
   always_comb begin
      lastAddr = {1'b0, req.addr} + {12'h000, req.count} - 17'h00001;
      addrBad  = (req.count == 5'h00) || (lastAddr > {1'b0, ADDR_LAST});
   end

   // Next-state of bank, answer and snapshot
   always_comb begin
      setpointNext = setpointReg;
      runCmdNext   = runCmdReg;
      rspValidNext = 1'b0;
      rspErrorNext = 1'b0;
      errCodeNext  = 8'h00;
      snapNext     = snapReg;
      if (req.valid) begin
         rspValidNext = 1'b1;
         if (addrBad) begin
            rspErrorNext = 1'b1;
            errCodeNext  = ERR_BAD_ADDR;
         end else if (req.write) begin
            // only 0Bh and 0Ch hold state; others ignore writes
            if (req.addr == ADDR_SETPOINT && plant.remoteSerial) begin
               setpointNext = setpClamped;
            end
            if (req.addr == ADDR_RUN_CMD && plant.remoteSerial) begin
               runCmdNext = req.data[0];
            end
         end else begin
            // whole bank captured in one cycle
            snapNext = liveWords;
         end
      end
   end

   // Registers only; plant state is sampled on in-range reads and held in the snapshot until the next in-range read or a reset clears it
   always_ff @(posedge sys_clk) begin
      if (sys_rst) begin
         setpointReg <= SETP_RESET;
         runCmdReg   <= RUN_CMD_RESET;
         rspValidReg <= 1'b0;
         rspErrorReg <= 1'b0;
         errCodeReg  <= 8'h00;
         snapReg     <= '0;
      end else begin
         setpointReg <= setpointNext;
         runCmdReg   <= runCmdNext;
         rspValidReg <= rspValidNext;
         rspErrorReg <= rspErrorNext;
         errCodeReg  <= errCodeNext;
         snapReg     <= snapNext;
      end
   end

   assign rspValid   = rspValidReg;
   assign rspError   = rspErrorReg;
   assign rspErrCode = errCodeReg;
   assign rspWords   = snapReg;
   assign setpoint   = setpointReg;
   assign runCommand = runCmdReg;

   // Checks next to the logic
   sequence remoteSetpWrite_s;
      req.valid && req.write && !addrBad && req.addr == ADDR_SETPOINT && plant.remoteSerial;
   endsequence

   sequence localWrite_s;
      req.valid && req.write && !plant.remoteSerial;
   endsequence

   sequence goodRead_s;
      req.valid && !req.write && !addrBad;
   endsequence

   setp_clamp_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      remoteSetpWrite_s |=> setpointReg == $past(setpClamped))
      else $error("setpoint not clamped value");

   setp_range_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      remoteSetpWrite_s |=> setpointReg >= $past(setpMin) && setpointReg <= $past(setpMax))
      else $error("setpoint out of range");

   local_hold_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      localWrite_s |=> $stable(setpointReg) && $stable(runCmdReg))
      else $error("write accepted outside remote mode");

   run_cmd_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && req.write && plant.remoteSerial && req.addr == ADDR_RUN_CMD
      && !addrBad |=> runCmdReg == $past(req.data[0]))
      else $error("run command not taken");

   bad_addr_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && addrBad |=> rspValid && rspError && rspErrCode == ERR_BAD_ADDR)
      else $error("bad address not rejected");

   snap_temp_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && !req.write && !addrBad
      |=> rspWords[15:0] == $past(plant.panelPresentValue))
      else $error("temperature word mismatch");

   cond_zero_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && !req.write && !addrBad && !plant.sensorEnabled
      |=> rspWords[ADDR_FLUID_COND*16 +: 16] == 16'h0000)
      else $error("sensor word not zero");

   run_flag_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && !req.write && !addrBad
      |=> rspWords[ADDR_STATUS_PRI*16 + BIT_RUN] == $past(plant.running)
       && rspWords[ADDR_STATUS_PRI*16 + BIT_REMOTE] == $past(plant.remoteSerial))
      else $error("status run or remote bit wrong");

   rsvd_zero_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      rspValid |-> rspWords[16 +: 16] == 16'h0000 && rspWords[8*16 +: 16] == 16'h0000)
      else $error("reserved word nonzero");

   rsp_once_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      !req.valid |=> !rspValid)
      else $error("answer without request");

   rsp_next_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid |=> rspValid)
      else $error("request left unanswered");

   rsp_clean_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && !addrBad |=> !rspError && rspErrCode == 8'h00)
      else $error("good request flagged as error");

   err_no_state_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && addrBad
      |=> $stable(setpointReg) && $stable(runCmdReg) && $stable(snapReg))
      else $error("rejected request changed state");

   press_word_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      goodRead_s |=> rspWords[ADDR_DISCH_PRESS*16 +: 16] == $past(plant.dischPressure))
      else $error("pressure word mismatch");

   cond_word_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      req.valid && !req.write && !addrBad && plant.sensorEnabled
      |=> rspWords[ADDR_FLUID_COND*16 +: 16] == $past(plant.fluidCond))
      else $error("sensor word mismatch");

   alarm_bits_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      goodRead_s |=> rspWords[ADDR_STATUS_PRI*16 + BIT_STOP_ALARM] == $past(plant.stopAlarm)
       && rspWords[ADDR_STATUS_PRI*16 + BIT_CONT_ALARM] == $past(plant.contAlarm))
      else $error("alarm kind bits wrong");

   unit_bits_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      goodRead_s |=> rspWords[ADDR_STATUS_PRI*16 + BIT_PRESS_UNIT] == $past(plant.pressUnitPsi)
       && rspWords[ADDR_STATUS_PRI*16 + BIT_TEMP_UNIT] == $past(plant.tempUnitF))
      else $error("unit bits wrong");

   ready_fill_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      goodRead_s |=> rspWords[ADDR_STATUS_PRI*16 + BIT_TEMP_READY] == $past(plant.tempReady)
       && rspWords[ADDR_STATUS_PRI*16 + BIT_AUTO_FILL] == $past(plant.autoFillActive))
      else $error("ready or fill bit wrong");

   setting_bits_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      goodRead_s |=> rspWords[ADDR_STATUS_PRI*16 + BIT_RUN_TIMER +: 4]
       == $past({plant.antiFreezeSet, plant.restartPfSet, plant.stopTimerSet, plant.runTimerSet}))
      else $error("settings bits wrong");

   sensor_code_a: assert property (
      @(posedge sys_clk) disable iff (sys_rst)
      goodRead_s
      |=> rspWords[ADDR_STATUS_SEC*16 +: 16] == {14'h0000, $past(plant.sensorSel)})
      else $error("second status word wrong");

endmodule : chiller_process_register_map

// [sim/host_req_model.sv]
`timescale 1ns/1ps
module host_req_model
   import chiller_regs_pkg::*;
(
   input  wire logic sys_clk,
   output reg_req_s  req
);
   initial req = '0;

   // one request per call, with any word count
   // Held from just after one edge through the taking edge, then scrambled
   // so a design that samples late never sees stale but plausible fields
   task automatic issue(input logic w, input logic [15:0] a, input logic [4:0] c,
                        input logic [15:0] d);
      @(posedge sys_clk);
      #1 req = '{valid: 1'b1, write: w, addr: a, count: c, data: d};
      @(posedge sys_clk);
      #1 req = '{valid: 1'b0, write: ~w, addr: ~a, count: ~c, data: ~d};
   endtask : issue
endmodule : host_req_model

// [sim/chiller_process_register_map_bench.sv]
`timescale 1ns/1ps
module chiller_process_register_map_bench
   import chiller_regs_pkg::*;
;
   logic                     sys_clk;
   logic                     sys_rst;
   plant_s                   plant;
   reg_req_s                 req;
   logic                     reqReady;
   logic                     rspValid;
   logic                     rspError;
   logic                     runCommand;
   logic [7:0]               rspErrCode;
   logic [WORD_COUNT*16-1:0] rspWords;
   logic [15:0]              setpoint;
   int                       miscompares = 0;
   int                       checks_done = 0;
   int                       cycles = 0;
   // Rows: flag k one-hot in, status bit pos[k] out
   int                       pos [12] = '{0, 1, 2, 4, 5, 9, 10, 11, 12, 13, 14, 15};
   int                       rsv [6] = '{1, 8, 10, 13, 14, 15};

   chiller_process_register_map i_chiller_process_register_map (
      .sys_clk    (sys_clk),
      .sys_rst    (sys_rst),
      .plant      (plant),
      .req        (req),
      .reqReady   (reqReady),
      .rspValid   (rspValid),
      .rspError   (rspError),
      .rspErrCode (rspErrCode),
      .rspWords   (rspWords),
      .setpoint   (setpoint),
      .runCommand (runCommand)
   );

   host_req_model i_host_req_model (
      .sys_clk (sys_clk),
      .req     (req)
   );

   // Free-running 10 MHz clock
   initial begin
      sys_clk = 1'b0;
      forever #50 sys_clk = ~sys_clk;
   end

   // Hang guard, far above the roughly 75 cycles the run needs
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 3000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      checks_done++;
      if (seen !== exp) begin
         miscompares++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   function automatic logic [15:0] wd(input int n);
      return rspWords[n*16 +: 16];
   endfunction : wd

   task automatic xfer(input logic w, input logic [15:0] a, input logic [4:0] c,
                       input logic [15:0] d);
      i_host_req_model.issue(w, a, c, d);
      chk("rspValid", {15'h0, rspValid}, 16'h0001);
   endtask : xfer

   // Address check: code 02 when the span leaves the bank or the count is zero
   task automatic try(input logic [15:0] a, input logic [4:0] c, input logic e);
      xfer(1'b0, a, c, 16'h0);
      chk("rspError", {15'h0, rspError}, {15'h0, e});
      chk("rspErrCode", {8'h0, rspErrCode}, e ? 16'h0002 : 16'h0000);
   endtask : try

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : tally_and_finish

   // Main sequence
   initial begin
      sys_rst = 1'b1;
      plant = '0;
      repeat (6) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      chk("setpoint", setpoint, 16'h0190);
      chk("runCommand", {15'h0, runCommand}, 16'h0000);
      chk("rspValidRst", {15'h0, rspValid}, 16'h0000);
      chk("reqReady", {15'h0, reqReady}, 16'h0001);
      chk("snapRst0", wd(0), 16'h0000);
      // Flags running..autoFillActive sit contiguously at plant[14:3]
      for (int k = 0; k < 12; k++) begin
         plant[14:3] = 12'h800 >> k;
         xfer(1'b0, ADDR_STATUS_PRI, 5'd1, 16'h0);
         chk("status1", wd(4), 16'h0001 << pos[k]);
      end
      plant = '0;
      plant.panelPresentValue = 16'hfbb4;
      plant.dischPressure = 16'h012c;
      plant.fluidCond = 16'h01e0;
      plant.alarmA = 16'h8001;
      plant.alarmB = 16'h0f0f;
      plant.alarmC = 16'h000f;
      plant.sensorEnabled = 1'b1;
      plant.sensorSel = 2'h2;
      xfer(1'b0, 16'h0000, 5'd16, 16'h0);
      chk("temp", wd(0), 16'hfbb4);
      chk("press", wd(2), 16'h012c);
      chk("cond", wd(3), 16'h01e0);
      chk("alarmA", wd(5), 16'h8001);
      chk("alarmB", wd(6), 16'h0f0f);
      chk("alarmC", wd(7), 16'h000f);
      chk("status2", wd(9), 16'h0002);
      foreach (rsv[i])
         chk("reserved", wd(rsv[i]), 16'h0000);
      plant.sensorEnabled = 1'b0;
      xfer(1'b0, ADDR_FLUID_COND, 5'd1, 16'h0);
      chk("condOff", wd(3), 16'h0000);
      // Answer stands one cycle only
      @(posedge sys_clk);
      #1 chk("rspIdle", {15'h0, rspValid}, 16'h0000);
      plant.sensorEnabled = 1'b1;
      plant.sensorSel = 2'h1;
      plant.fluidCond = 16'h002d;
      xfer(1'b0, ADDR_FLUID_COND, 5'd1, 16'h0);
      chk("resist", wd(3), 16'h002d);
      chk("status2R", wd(9), 16'h0001);
      try(16'h0100, 5'd7, 1'b1);
      try(16'h000e, 5'd3, 1'b1);
      try(16'h0000, 5'd0, 1'b1);
      try(16'h000f, 5'd1, 1'b0);
      // Local mode: writes are answered but dropped
      xfer(1'b1, ADDR_SETPOINT, 5'd1, 16'h018f);
      chk("setpLocal", setpoint, 16'h0190);
      xfer(1'b1, ADDR_RUN_CMD, 5'd1, 16'h0001);
      chk("runLocal", {15'h0, runCommand}, 16'h0000);
      plant.remoteSerial = 1'b1;
      xfer(1'b1, ADDR_SETPOINT, 5'd1, 16'h018f);
      chk("setp", setpoint, 16'h018f);
      xfer(1'b1, ADDR_SETPOINT, 5'd1, 16'h0500);
      chk("setpHiC", setpoint, 16'h0190);
      xfer(1'b1, ADDR_SETPOINT, 5'd1, 16'h0001);
      chk("setpLoC", setpoint, 16'h0032);
      plant.tempUnitF = 1'b1;
      xfer(1'b1, ADDR_SETPOINT, 5'd1, 16'h0001);
      chk("setpLoF", setpoint, 16'h019a);
      xfer(1'b1, ADDR_SETPOINT, 5'd1, 16'h0500);
      chk("setpHiF", setpoint, 16'h0410);
      xfer(1'b1, ADDR_RUN_CMD, 5'd1, 16'h0001);
      chk("run", {15'h0, runCommand}, 16'h0001);
      // Writes to read-only and reserved words must leave no trace
      xfer(1'b1, ADDR_DISCH_TEMP, 5'd1, 16'h1234);
      xfer(1'b1, 16'h000d, 5'd1, 16'h5555);
      xfer(1'b0, 16'h0000, 5'd16, 16'h0);
      chk("roTemp", wd(0), 16'hfbb4);
      chk("rsvD", wd(13), 16'h0000);
      chk("setpBack", wd(11), 16'h0410);
      chk("runBack", wd(12), 16'h0001);
      xfer(1'b1, ADDR_RUN_CMD, 5'd1, 16'h0000);
      chk("runStop", {15'h0, runCommand}, 16'h0000);
      xfer(1'b1, ADDR_RUN_CMD, 5'd1, 16'h0001);
      // Second reset in mid-run
      sys_rst = 1'b1;
      @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      chk("setpRst", setpoint, 16'h0190);
      chk("runRst", {15'h0, runCommand}, 16'h0000);
      chk("snapRst", wd(0), 16'h0000);
      xfer(1'b0, ADDR_SETPOINT, 5'd1, 16'h0);
      chk("setpRead", wd(11), 16'h0190);
      tally_and_finish();
   end
endmodule : chiller_process_register_map_bench
